// File: verilog/menu_nav_defs.svh
// constants for the operator menu navigator: timing and value limits
// assumes a 10 MHz system clock
`ifndef MENU_NAV_DEFS_SVH
`define MENU_NAV_DEFS_SVH
`define CLK_HZ            10000000
`define MS_PER_S          1000
`define TICK_CYCLES       (`CLK_HZ / 1000)
`define LONG_PRESS_MS     2000
`define IDLE_TIMEOUT_MS   30000
`define PHASE_WAIT_MS     2000
`define TIMED_HOLD_MS     2000
`define MIN_HEAT_C        16'h0028
`define CAL_MAX_C         16'h0028
`define CAL_BASE_RESET    16'h0014
`define SEAL_RESET        16'h0000
`define PRE_RESET         16'h0000
`endif

// File: verilog/menu_nav_pkg.sv
// types for the operator menu navigator
// no assumptions beyond the defs header
package menu_nav_pkg;
    typedef enum logic [2:0] {
        home_item,
        seal_setpoint_item,
        preheat_setpoint_item,
        calibration_item,
        phase_correction_item,
        hold_mode_item,
        alarm_item
    } item_type;
    typedef enum logic [1:0] {
        hold_off,
        hold_on,
        timed_hold_option
    } hold_type;
endpackage

// File: verilog/menu_nav.sv
// operator menu navigator: keys, timeouts, alarm handling, start requests
// keys are raw pins; alarm and calibration status from same-clock logic
`timescale 1ns/1ps
`include "menu_nav_defs.svh"
module menu_nav
    import menu_nav_pkg::*;
#(
    parameter int LONG_MS  = `LONG_PRESS_MS,
    parameter int IDLE_MS  = `IDLE_TIMEOUT_MS,
    parameter int PHASE_MS = `PHASE_WAIT_MS,
    parameter int HOLD_MS  = `TIMED_HOLD_MS,
    parameter int TICK_CYC = `TICK_CYCLES
)
(
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // keypad pins
    input  wire logic        MENU_KEY,
    input  wire logic        UP_KEY,
    input  wire logic        DOWN_KEY,
    input  wire logic        ENTER_KEY,
    input  wire logic        RESET_KEY,
    input  wire logic        MANUAL_HEAT_KEY,
    // controller status
    input  wire logic        ALARM_ACTIVE,
    input  wire logic        PREHEAT_SELECT,
    input  wire logic [15:0] SETPOINT_MAX,
    input  wire logic [15:0] ACTUAL_TEMP,
    input  wire logic        HEAT_PHASE_END,
    input  wire logic        CAL_DONE,
    input  wire logic        CAL_OK,
    input  wire logic [1:0]  PHASE_MODE,
    input  wire logic [1:0]  HOLD_MODE_SEL,
    // display and requests
    output logic [2:0]       MENU_ITEM,
    output logic [15:0]      DISPLAY_VALUE,
    output logic             HOLD_LED,
    output logic             LABEL_FLASH,
    output logic [15:0]      SEAL_SETPOINT,
    output logic [15:0]      PREHEAT_SETPOINT,
    output logic [15:0]      CAL_BASE_TEMP,
    output logic             CAL_START,
    output logic             PHASE_START,
    output logic             HEAT_START,
    output logic [15:0]      HEAT_TARGET,
    output logic             ERROR_ACK,
    output logic             CAL_ERROR
);
    // phase mode codes: 0 off, 1 on, 2 automatic
    function automatic logic [15:0] step_up(input logic [15:0] v,
                                            input logic [15:0] mx);
        if (v == 16'h0000)
            step_up = (`MIN_HEAT_C <= mx) ? `MIN_HEAT_C : v;
        else if (v < mx)
            step_up = v + 16'h0001;
        else
            step_up = v;
    endfunction

    function automatic logic [15:0] step_dn(input logic [15:0] v);
        if (v <= `MIN_HEAT_C)
            step_dn = 16'h0000;
        else
            step_dn = v - 16'h0001;
    endfunction

    logic [5:0]  s1_reg;
    logic [5:0]  s2_reg;
    logic [5:0]  k_reg;
    logic [5:0]  kp_reg;
    logic [15:0] tick_cnt_reg;
    logic        tick_reg;
    logic [15:0] press_ms_reg;
    logic [15:0] idle_ms_reg;
    logic [15:0] phase_ms_reg;
    logic [15:0] hold_ms_reg;
    logic        alarm_prev_reg;
    logic        cal_busy_reg;
    logic        long_fired_reg;
    logic [15:0] held_reg;
    item_type    item_reg;
    item_type    item_next;

    wire logic [5:0] rise = k_reg & ~kp_reg;
    wire logic menu_rel  = kp_reg[0] & ~k_reg[0];
    wire logic up_p      = rise[1];
    wire logic dn_p      = rise[2];
    wire logic ent_p     = rise[3];
    wire logic rst_p     = rise[4];
    wire logic man_p     = rise[5];
    wire logic any_p     = |rise;
    wire logic short_rel = menu_rel && !long_fired_reg &&
                           press_ms_reg < 16'(LONG_MS);
    // held or just released: a release right at the limit still counts long
    wire logic long_now  = kp_reg[0] && !long_fired_reg &&
                           press_ms_reg >= 16'(LONG_MS);
    wire logic alarm_rise = ALARM_ACTIVE && !alarm_prev_reg;
    wire logic cal_good  = CAL_DONE && CAL_OK;

    // key synchronisers and edge history
    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
        begin
            s1_reg <= 6'h00;
            s2_reg <= 6'h00;
            k_reg  <= 6'h00;
            kp_reg <= 6'h00;
        end
        else
        begin
            s1_reg <= {MANUAL_HEAT_KEY, RESET_KEY, ENTER_KEY,
                       DOWN_KEY, UP_KEY, MENU_KEY};
            s2_reg <= s1_reg;
            k_reg  <= s2_reg;
            kp_reg <= k_reg;
        end

    // millisecond tick
    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
        begin
            tick_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
        end
        else if (tick_cnt_reg == 16'(TICK_CYC - 1))
        begin
            tick_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b1;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
            tick_reg     <= 1'b0;
        end

    // menu press length, counted from press to release
    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
        begin
            press_ms_reg   <= 16'h0000;
            long_fired_reg <= 1'b0;
        end
        else if (rise[0])
        begin
            press_ms_reg   <= 16'h0000;
            long_fired_reg <= 1'b0;
        end
        else
        begin
            if (k_reg[0] && tick_reg && press_ms_reg != 16'hffff)
                press_ms_reg <= press_ms_reg + 16'h0001;
            if (long_now)
                long_fired_reg <= 1'b1;
        end

    // inactivity timer
    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
            idle_ms_reg <= 16'h0000;
        else if (any_p || item_reg != item_next)
            idle_ms_reg <= 16'h0000;
        else if (tick_reg && idle_ms_reg != 16'hffff)
            idle_ms_reg <= idle_ms_reg + 16'h0001;

    // phase item wait timer
    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
            phase_ms_reg <= 16'h0000;
        else if (item_reg != phase_correction_item)
            phase_ms_reg <= 16'h0000;
        else if (tick_reg && phase_ms_reg != 16'hffff)
            phase_ms_reg <= phase_ms_reg + 16'h0001;

    // menu position
    always_comb
    begin
        item_next = item_reg;
        if (alarm_rise)
            item_next = alarm_item;
        else if (long_now)
            item_next = ALARM_ACTIVE ? alarm_item : home_item;
        else if (cal_busy_reg && CAL_DONE)
        begin
            if (cal_good && PHASE_MODE == 2'h1)
                item_next = phase_correction_item;
            else if (!cal_good && ALARM_ACTIVE)
                item_next = alarm_item;
            else
                item_next = home_item;
        end
        else if (cal_busy_reg)
            item_next = item_reg;
        else
            case (item_reg)
                alarm_item:
                    if (rst_p)
                        item_next = home_item;
                    else if (short_rel)
                        item_next = calibration_item;
                home_item:
                    if (short_rel)
                        item_next = seal_setpoint_item;
                seal_setpoint_item:
                    if (short_rel)
                        item_next = preheat_setpoint_item;
                preheat_setpoint_item:
                    if (short_rel)
                        item_next = calibration_item;
                calibration_item:
                    if (short_rel)
                        item_next = phase_correction_item;
                phase_correction_item:
                    if (short_rel)
                        item_next = hold_mode_item;
                    else if (ent_p || phase_ms_reg >= 16'(PHASE_MS))
                        item_next = home_item;
                hold_mode_item:
                    if (short_rel)
                        item_next = home_item;
                default:
                    item_next = home_item;
            endcase
        if (!alarm_rise && !long_now && !cal_busy_reg &&
            idle_ms_reg >= 16'(IDLE_MS) &&
            item_next != calibration_item && item_next != alarm_item)
            item_next = home_item;
    end

    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
        begin
            item_reg       <= home_item;
            alarm_prev_reg <= 1'b0;
        end
        else
        begin
            item_reg       <= item_next;
            alarm_prev_reg <= ALARM_ACTIVE;
        end

    // setpoints
    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
        begin
            SEAL_SETPOINT    <= `SEAL_RESET;
            PREHEAT_SETPOINT <= `PRE_RESET;
            CAL_BASE_TEMP    <= `CAL_BASE_RESET;
        end
        else if (item_reg == seal_setpoint_item && up_p)
            SEAL_SETPOINT <= step_up(SEAL_SETPOINT, SETPOINT_MAX);
        else if (item_reg == seal_setpoint_item && dn_p)
            SEAL_SETPOINT <= step_dn(SEAL_SETPOINT);
        else if (item_reg == preheat_setpoint_item && up_p)
            PREHEAT_SETPOINT <= step_up(PREHEAT_SETPOINT,
                                        SETPOINT_MAX);
        else if (item_reg == preheat_setpoint_item && dn_p)
            PREHEAT_SETPOINT <= step_dn(PREHEAT_SETPOINT);
        else if (item_reg == calibration_item && !cal_busy_reg && up_p &&
                 CAL_BASE_TEMP < `CAL_MAX_C)
            CAL_BASE_TEMP <= CAL_BASE_TEMP + 16'h0001;
        else if (item_reg == calibration_item && !cal_busy_reg && dn_p &&
                 CAL_BASE_TEMP != 16'h0000)
            CAL_BASE_TEMP <= CAL_BASE_TEMP - 16'h0001;

    // calibration, phase correction and heat requests
    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
        begin
            cal_busy_reg <= 1'b0;
            CAL_START    <= 1'b0;
            PHASE_START  <= 1'b0;
            HEAT_START   <= 1'b0;
            HEAT_TARGET  <= 16'h0000;
            ERROR_ACK    <= 1'b0;
            CAL_ERROR    <= 1'b0;
            LABEL_FLASH  <= 1'b0;
        end
        else
        begin
            CAL_START   <= item_reg == calibration_item && ent_p &&
                           !cal_busy_reg;
            PHASE_START <= (item_reg == phase_correction_item && ent_p) ||
                           (cal_busy_reg && cal_good &&
                            PHASE_MODE == 2'h2);
            ERROR_ACK   <= item_reg == alarm_item && rst_p;
            HEAT_START  <= item_reg == home_item && man_p &&
                           SEAL_SETPOINT >= `MIN_HEAT_C &&
                           (!PREHEAT_SELECT ||
                            PREHEAT_SETPOINT >= `MIN_HEAT_C);
            if (man_p)
                HEAT_TARGET <= (PREHEAT_SELECT &&
                                PREHEAT_SETPOINT != 16'h0000) ?
                               PREHEAT_SETPOINT : SEAL_SETPOINT;
            if (item_reg == calibration_item && ent_p)
                cal_busy_reg <= 1'b1;
            else if (CAL_DONE)
                cal_busy_reg <= 1'b0;
            LABEL_FLASH <= cal_busy_reg && !CAL_DONE;
            if (cal_busy_reg && CAL_DONE)
                CAL_ERROR <= !CAL_OK;
            else if (ERROR_ACK)
                CAL_ERROR <= 1'b0;
        end

    // hold capture and display value
    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
        begin
            held_reg      <= 16'h0000;
            hold_ms_reg   <= 16'h0000;
            HOLD_LED      <= 1'b0;
            DISPLAY_VALUE <= 16'h0000;
            MENU_ITEM     <= 3'h0;
        end
        else
        begin
            MENU_ITEM <= item_reg;
            if (HEAT_PHASE_END)
                held_reg <= ACTUAL_TEMP;
            if (HEAT_PHASE_END)
                hold_ms_reg <= 16'h0000;
            else if (tick_reg && hold_ms_reg != 16'hffff)
                hold_ms_reg <= hold_ms_reg + 16'h0001;
            case (hold_type'(HOLD_MODE_SEL))
                hold_on:
                begin
                    HOLD_LED      <= 1'b1;
                    DISPLAY_VALUE <= held_reg;
                end
                timed_hold_option:
                begin
                    HOLD_LED      <= hold_ms_reg < 16'(HOLD_MS);
                    DISPLAY_VALUE <= (hold_ms_reg < 16'(HOLD_MS)) ?
                                     held_reg : ACTUAL_TEMP;
                end
                default:
                begin
                    HOLD_LED      <= 1'b0;
                    DISPLAY_VALUE <= ACTUAL_TEMP;
                end
            endcase
        end

    property p_alarm_force;
        @(posedge SYS_CLK) disable iff (RST)
        (ALARM_ACTIVE && !alarm_prev_reg) |=> item_reg == alarm_item;
    endproperty
    a_alarm_force: assert property (p_alarm_force)
        else $error("alarm did not force alarm item");

    property p_long_press;
        @(posedge SYS_CLK) disable iff (RST)
        (kp_reg[0] && !long_fired_reg && press_ms_reg == 16'(LONG_MS)
         && !alarm_rise && !ALARM_ACTIVE) |=> item_reg == home_item;
    endproperty
    a_long_press: assert property (p_long_press)
        else $error("long press did not return home");

    property p_short_adv;
        @(posedge SYS_CLK) disable iff (RST)
        (short_rel && item_reg == home_item && !alarm_rise &&
         !cal_busy_reg) |=> item_reg == seal_setpoint_item;
    endproperty
    a_short_adv: assert property (p_short_adv)
        else $error("short press did not advance");

    property p_idle;
        @(posedge SYS_CLK) disable iff (RST)
        (idle_ms_reg >= 16'(IDLE_MS) && !cal_busy_reg && !alarm_rise &&
         !long_now && item_reg == hold_mode_item)
        |=> item_reg == home_item;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle timeout did not return home");

    property p_no_idle_alarm;
        @(posedge SYS_CLK) disable iff (RST)
        (item_reg == alarm_item && !any_p && !long_now &&
         !short_rel && !cal_busy_reg) |=> item_reg == alarm_item;
    endproperty
    a_no_idle_alarm: assert property (p_no_idle_alarm)
        else $error("alarm item left without a key");

    property p_ack;
        @(posedge SYS_CLK) disable iff (RST)
        (item_reg == alarm_item && rst_p && !alarm_rise && !long_now &&
         !cal_busy_reg) |=> ERROR_ACK && item_reg == home_item;
    endproperty
    a_ack: assert property (p_ack)
        else $error("reset key did not acknowledge");

    property p_heat_inhibit;
        @(posedge SYS_CLK) disable iff (RST)
        HEAT_START |-> $past(SEAL_SETPOINT) >= `MIN_HEAT_C;
    endproperty
    a_heat_inhibit: assert property (p_heat_inhibit)
        else $error("heat started below minimum setpoint");

    sequence s_cal_fail;
        cal_busy_reg && CAL_DONE && !CAL_OK;
    endsequence
    property p_cal_fail;
        @(posedge SYS_CLK) disable iff (RST)
        s_cal_fail |=> CAL_ERROR && !PHASE_START;
    endproperty
    a_cal_fail: assert property (p_cal_fail)
        else $error("failed calibration raised no error");

    property p_hold_off;
        @(posedge SYS_CLK) disable iff (RST)
        HOLD_MODE_SEL == 2'h0 |=> DISPLAY_VALUE == $past(ACTUAL_TEMP)
                                  && !HOLD_LED;
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("hold off showed captured value");
endmodule

// File: dv/keypad_model.sv
// keypad side of the operator terminal: presses one key at a time
// assumes the navigator samples keys on the rising edge of its clock
`timescale 1ns/1ps
module keypad_model
#(
    parameter int TICK_CYC = 10
)
(
    // clock
    input  wire logic       clk,
    // key pins, active high, idle low
    output logic      [5:0] keys
);
    initial keys = 6'h00;

    // hold key k for ms ticks, then leave a quiet gap for the sync stages
    task automatic press(input int k, input int ms);
        @(posedge clk);
        keys[k] <= 1'b1;
        repeat (ms * TICK_CYC) @(posedge clk);
        keys[k] <= 1'b0;
        repeat (3 * TICK_CYC) @(posedge clk);
    endtask
endmodule

// File: dv/tb_operator_menu_navigator.sv
// self-checking bench for the operator menu navigator
// assumes short timing parameters: a tick is 10 cycles, counts in ticks
`timescale 1ns/1ps
module tb_operator_menu_navigator;
    import menu_nav_pkg::*;
    localparam int TK = 10;
    localparam int LM = 20;
    localparam int IM = 60;
    localparam int PM = 20;
    localparam int HM = 20;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  keys;
    logic        alarm = 1'b0;
    logic        pre_sel = 1'b0;
    logic [15:0] smax = 16'h002a;
    logic [15:0] actual = 16'h0000;
    logic        phase_end = 1'b0;
    logic        cal_done = 1'b0;
    logic        cal_ok = 1'b0;
    logic [1:0]  pmode = 2'h0;
    logic [1:0]  hmode = 2'h0;
    logic [2:0]  item;
    logic [15:0] disp;
    logic        hold_led;
    logic        flash;
    logic [15:0] seal;
    logic [15:0] pre;
    logic [15:0] cal_base;
    logic        cal_start;
    logic        phase_start;
    logic        heat_start;
    logic [15:0] target;
    logic        err_ack;
    logic        cal_err;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          heat_n = 0;
    int          cal_n = 0;
    int          ph_n = 0;
    int          ack_n = 0;
    logic [15:0] a;
    logic [15:0] b;

    initial forever #50 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        heat_n <= heat_n + heat_start;
        cal_n  <= cal_n + cal_start;
        ph_n   <= ph_n + phase_start;
        ack_n  <= ack_n + err_ack;
    end

    keypad_model #(.TICK_CYC(TK)) keypad_model_i (.clk(sys_clk), .keys(keys));

    menu_nav #(.LONG_MS(LM), .IDLE_MS(IM), .PHASE_MS(PM), .HOLD_MS(HM),
               .TICK_CYC(TK)) menu_nav_i (
        .SYS_CLK(sys_clk), .RST(rst), .MENU_KEY(keys[0]), .UP_KEY(keys[1]),
        .DOWN_KEY(keys[2]), .ENTER_KEY(keys[3]), .RESET_KEY(keys[4]),
        .MANUAL_HEAT_KEY(keys[5]), .ALARM_ACTIVE(alarm),
        .PREHEAT_SELECT(pre_sel), .SETPOINT_MAX(smax), .ACTUAL_TEMP(actual),
        .HEAT_PHASE_END(phase_end), .CAL_DONE(cal_done), .CAL_OK(cal_ok),
        .PHASE_MODE(pmode), .HOLD_MODE_SEL(hmode), .MENU_ITEM(item),
        .DISPLAY_VALUE(disp), .HOLD_LED(hold_led), .LABEL_FLASH(flash),
        .SEAL_SETPOINT(seal), .PREHEAT_SETPOINT(pre),
        .CAL_BASE_TEMP(cal_base), .CAL_START(cal_start),
        .PHASE_START(phase_start), .HEAT_START(heat_start),
        .HEAT_TARGET(target), .ERROR_ACK(err_ack), .CAL_ERROR(cal_err));

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic ms(input int n);
        repeat (n * TK) @(posedge sys_clk);
    endtask

    task automatic menu_short();
        keypad_model_i.press(0, 3);
    endtask

    // long press lands home, then short presses walk to item n
    task automatic go(input int n);
        keypad_model_i.press(0, LM + 2);
        repeat (n) menu_short();
    endtask

    task automatic cal_finish(input logic ok, input logic [1:0] m);
        @(posedge sys_clk);
        pmode    <= m;
        cal_ok   <= ok;
        cal_done <= 1'b1;
        @(posedge sys_clk);
        cal_done <= 1'b0;
        ms(1);
    endtask

    task automatic heat_end(input logic [15:0] v);
        @(posedge sys_clk);
        actual <= v;
        repeat (4) @(posedge sys_clk);
        phase_end <= 1'b1;
        @(posedge sys_clk);
        phase_end <= 1'b0;
        actual <= ~v;
        ms(1);
    endtask

    function automatic logic [2:0] next_item(input int i);
        return (i == 5) ? 3'h0 : 3'(i + 1);
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        $display("BAD watchdog expected done seen hang");
        final_report();
    end

    initial
    begin
        void'($urandom(20));
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        ms(1);
        chk("item reset", 16'h0000, 16'(item));
        chk("cal base reset", 16'h0014, cal_base);
        keypad_model_i.press(5, 2);
        chk("heat refused", 16'h0000, 16'(heat_n));
        for (int i = 0; i < 6; i++)
        begin
            keypad_model_i.press(0, (i == 0) ? LM - 2 : 3);
            chk("menu step", 16'(next_item(i)), 16'(item));
        end
        $display("test navigation done");
        menu_short();
        keypad_model_i.press(0, LM + 1);
        chk("long press", 16'h0000, 16'(item));
        repeat (5) menu_short();
        ms(IM + 5);
        chk("idle return", 16'h0000, 16'(item));
        menu_short();
        for (int i = 0; i < 5; i++)
        begin
            keypad_model_i.press((i < 4) ? 1 : 2, 2);
            chk("seal step", (i == 0) ? 16'h0028 : (i == 4) ? 16'h0029
                : (i == 1) ? 16'h0029 : 16'h002a, seal);
        end
        menu_short();
        keypad_model_i.press(1, 2);
        chk("preheat up", 16'h0028, pre);
        keypad_model_i.press(2, 2);
        chk("preheat off", 16'h0000, pre);
        go(0);
        keypad_model_i.press(5, 2);
        chk("heat start", 16'h0001, 16'(heat_n));
        chk("heat target", 16'h0029, target);
        pre_sel <= 1'b1;
        keypad_model_i.press(5, 2);
        chk("preheat refused", 16'h0001, 16'(heat_n));
        go(2);
        keypad_model_i.press(1, 2);
        go(0);
        keypad_model_i.press(5, 2);
        chk("preheat heat", 16'h0002, 16'(heat_n));
        chk("preheat target", 16'h0028, target);
        pre_sel <= 1'b0;
        $display("test setpoints done");
        go(3);
        keypad_model_i.press(1, 2);
        chk("cal base up", 16'h0015, cal_base);
        keypad_model_i.press(3, 2);
        chk("cal start", 16'h0001, 16'(cal_n));
        chk("label flash", 16'h0001, 16'(flash));
        ms(IM + 5);
        chk("cal no idle", 16'h0003, 16'(item));
        cal_finish(1'b1, 2'h1);
        chk("to phase item", 16'h0004, 16'(item));
        chk("flash off", 16'h0000, 16'(flash));
        ms(PM + 3);
        chk("phase wait home", 16'h0000, 16'(item));
        go(4);
        keypad_model_i.press(3, 2);
        chk("phase enter", 16'h0001, 16'(ph_n));
        go(3);
        keypad_model_i.press(3, 2);
        cal_finish(1'b1, 2'h2);
        chk("auto phase", 16'h0002, 16'(ph_n));
        chk("auto home", 16'h0000, 16'(item));
        go(3);
        keypad_model_i.press(3, 2);
        cal_finish(1'b0, 2'h0);
        chk("cal error", 16'h0001, 16'(cal_err));
        chk("fail home", 16'h0000, 16'(item));
        $display("test calibration done");
        @(posedge sys_clk);
        alarm <= 1'b1;
        ms(1);
        chk("alarm force", 16'h0006, 16'(item));
        keypad_model_i.press(4, 2);
        chk("ack pulse", 16'h0001, 16'(ack_n));
        chk("error clear", 16'h0000, 16'(cal_err));
        chk("ack home", 16'h0000, 16'(item));
        keypad_model_i.press(0, LM + 2);
        chk("long to alarm", 16'h0006, 16'(item));
        ms(IM + 5);
        chk("alarm no idle", 16'h0006, 16'(item));
        menu_short();
        chk("alarm to cal", 16'h0003, 16'(item));
        @(posedge sys_clk);
        alarm <= 1'b0;
        $display("test alarm done");
        go(0);
        a = 16'($urandom());
        @(posedge sys_clk);
        hmode <= 2'h1;
        heat_end(a);
        chk("hold value", a, disp);
        chk("hold led", 16'h0001, 16'(hold_led));
        b = 16'($urandom());
        heat_end(b);
        chk("hold refresh", b, disp);
        @(posedge sys_clk);
        hmode <= 2'h2;
        heat_end(a);
        chk("timed value", a, disp);
        ms(HM + 3);
        chk("timed live", ~a, disp);
        chk("timed led", 16'h0000, 16'(hold_led));
        @(posedge sys_clk);
        hmode <= 2'h0;
        heat_end(b);
        chk("hold off live", ~b, disp);
        $display("test hold done");
        final_report();
    end
endmodule
